// ==== rtl/scd_pkg.sv ====
// Package of types and constants for the selectable clock divider
package scd_pkg;

  // Rate of the sampling clock
  localparam int unsigned CLOCK_HZ = 10_000_000;

  // Pins taken through the synchroniser
  localparam int unsigned SYNC_W   = 4;
  localparam int unsigned PIN_ECLP = 0;
  localparam int unsigned PIN_ECLN = 1;
  localparam int unsigned PIN_TTL  = 2;
  localparam int unsigned PIN_SEL  = 3;
  localparam logic [3:0]  SYNC_RST = 4'h0;

  // Select pin levels
  localparam logic SEL_ECL = 1'b0;
  localparam logic SEL_TTL = 1'b1;

  // Divider phase counter counts down
  localparam int unsigned  PHASE_W   = 2;
  localparam logic [1:0]   PHASE_RST = 2'h0;
  localparam logic [1:0]   PHASE_DEC = 2'h1;

  // True and complementary divided clocks
  typedef struct packed {
    logic half;
    logic half_n;
    logic quarter;
    logic quarter_n;
  } scd_clk_out_t;

  // Raw reference pins
  typedef struct packed {
    logic ecl_p;
    logic ecl_n;
    logic ttl;
    logic sel;
  } scd_ref_pins_t;

  localparam scd_clk_out_t OUT_RST = '{half: 1'b0, half_n: 1'b1,
                                       quarter: 1'b0, quarter_n: 1'b1};

endpackage

// ==== rtl/scd_sync.sv ====
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module scd_sync (
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  input  wire logic [scd_pkg::SYNC_W-1:0]  async_i,
  output var  logic [scd_pkg::SYNC_W-1:0]  sync_o
);

  logic [scd_pkg::SYNC_W-1:0] meta_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= scd_pkg::SYNC_RST;
      sync_o <= scd_pkg::SYNC_RST;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/scd_divider.sv ====
// Selectable reference clock divider with half and quarter rate outputs
// Summary of operation
// RULE1: Selected reference drives divide-by-two and divide-by-four clock outputs.
// RULE2: Reset low forces true outputs low, complements high, asynchronously.
// RULE3: Select low routes the differential pair as reference.
// RULE4: Select high routes the single-ended input as reference.
// RULE5: Half and quarter outputs start with coinciding rising edges.
// RULE6: Open or equal differential legs give a stable low reference.
// RULE7: After reset both dividers restart cleared, realigned on next reference edge.
`timescale 1ns/1ps
`default_nettype none

module scd_divider (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire scd_pkg::scd_ref_pins_t ref_pins_i,
  output var  scd_pkg::scd_clk_out_t  divided_clock_out_o
);

  logic [scd_pkg::SYNC_W-1:0]  pins_s;
  logic                        ecl_ref;
  logic                        ref_sel;
  logic                        ref_prev_q;
  logic                        ref_rise;
  logic [scd_pkg::PHASE_W-1:0] phase_q;
  logic [scd_pkg::PHASE_W-1:0] phase_d;

  scd_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({ref_pins_i.sel, ref_pins_i.ttl, ref_pins_i.ecl_n, ref_pins_i.ecl_p}),
    .sync_o  (pins_s)
  );

  // Only a true differential high counts; open legs read low
  assign ecl_ref = pins_s[scd_pkg::PIN_ECLP] & ~pins_s[scd_pkg::PIN_ECLN]; // see RULE6

  // Reference source mux
  always_comb begin
    if (pins_s[scd_pkg::PIN_SEL] == scd_pkg::SEL_TTL) begin
      ref_sel = pins_s[scd_pkg::PIN_TTL]; // see RULE4
    end else begin
      ref_sel = ecl_ref; // see RULE3
    end
  end

  // Rising edge of the chosen reference
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_sel;
    end
  end

  assign ref_rise = ref_sel & ~ref_prev_q;

  // Down count 0,3,2,1: both bits rise together leaving zero
  assign phase_d = phase_q - scd_pkg::PHASE_DEC; // see RULE5

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= scd_pkg::PHASE_RST; // see RULE7
    end else if (ref_rise) begin
      phase_q <= phase_d; // see RULE1
    end
  end

  // Phase code to true and complementary outputs
  function automatic scd_pkg::scd_clk_out_t phase_to_out(
    input logic [scd_pkg::PHASE_W-1:0] phase
  );
    scd_pkg::scd_clk_out_t outs;
    outs.half      = phase[0];
    outs.half_n    = ~phase[0];
    outs.quarter   = phase[1];
    outs.quarter_n = ~phase[1];
    return outs;
  endfunction

  // Output drivers kept in flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divided_clock_out_o <= scd_pkg::OUT_RST; // see RULE2
    end else if (ref_rise) begin
      divided_clock_out_o <= phase_to_out(phase_d); // see RULE1
    end
  end

  // Checks

  // Independent up count of reference edges since reset
  logic [scd_pkg::PHASE_W-1:0] edge_cnt_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_cnt_q <= scd_pkg::PHASE_RST;
    end else if (ref_rise) begin
      edge_cnt_q <= edge_cnt_q + scd_pkg::PHASE_DEC;
    end
  end

  // Bit pair whose top bit stays low while the synchroniser still shows its reset value
  logic [1:0]                  settle_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= {settle_q[0], 1'b1};
    end
  end

  sequence seq_cleared;
    !divided_clock_out_o.half && !divided_clock_out_o.quarter;
  endsequence

  sequence seq_both_high;
    divided_clock_out_o.half && divided_clock_out_o.quarter;
  endsequence

  sequence seq_quarter_only;
    !divided_clock_out_o.half && divided_clock_out_o.quarter;
  endsequence

  sequence seq_half_only;
    divided_clock_out_o.half && !divided_clock_out_o.quarter;
  endsequence

  AST_HALF_TOGGLE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    ref_rise |=> divided_clock_out_o.half != $past(divided_clock_out_o.half))
    else $error("Half rate output did not toggle on reference edge");

  AST_QUARTER_RATE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    ref_rise && divided_clock_out_o.half
    |=> divided_clock_out_o.quarter == $past(divided_clock_out_o.quarter))
    else $error("Quarter rate output changed on wrong phase");

  AST_HOLD_NO_EDGE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    !ref_rise |=> $stable(divided_clock_out_o))
    else $error("Outputs changed without a reference edge");

  AST_RESET_LEVELS: assert property (@(posedge clock_i) // see RULE2
    !rst_n_i |-> divided_clock_out_o == scd_pkg::OUT_RST)
    else $error("Outputs not at reset levels during reset");

  AST_COMPLEMENT: assert property (@(posedge clock_i) // see RULE2
    divided_clock_out_o.half_n == !divided_clock_out_o.half
    && divided_clock_out_o.quarter_n == !divided_clock_out_o.quarter)
    else $error("Complementary outputs do not mirror true outputs");

  AST_SEL_ECL: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE3
    pins_s[scd_pkg::PIN_SEL] == scd_pkg::SEL_ECL |-> ref_sel == ecl_ref)
    else $error("Differential source not routed while select low");

  AST_SEL_TTL: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE4
    pins_s[scd_pkg::PIN_SEL] == scd_pkg::SEL_TTL |-> ref_sel == pins_s[scd_pkg::PIN_TTL])
    else $error("Single ended source not routed while select high");

  AST_ALIGNED_RISE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE5
    $rose(divided_clock_out_o.quarter) |-> $rose(divided_clock_out_o.half))
    else $error("Quarter rate rose without half rate rising");

  AST_OPEN_PAIR: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE6
    pins_s[scd_pkg::PIN_ECLP] == pins_s[scd_pkg::PIN_ECLN] |-> !ecl_ref)
    else $error("Open differential pair produced a high reference");

  AST_RESTART: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE7
    $rose(rst_n_i) |-> seq_cleared ##0 phase_q == scd_pkg::PHASE_RST)
    else $error("Dividers did not restart cleared after reset");

  AST_FIRST_EDGE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE7
    seq_cleared ##0 ref_rise ##0 phase_q == scd_pkg::PHASE_RST |=> seq_both_high)
    else $error("First reference edge from cleared state not aligned");

  AST_EDGE_COUNT: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    divided_clock_out_o.half == edge_cnt_q[0]
    && divided_clock_out_o.quarter == (edge_cnt_q[1] ^ edge_cnt_q[0]))
    else $error("Outputs disagree with count of reference edges");

  AST_PHASE_MATCH: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    divided_clock_out_o == phase_to_out(phase_q))
    else $error("Outputs disagree with divider phase");

  AST_STEP_FROM_HIGH: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    seq_both_high ##0 ref_rise
    |=> seq_quarter_only)
    else $error("Step from both high went wrong");

  AST_STEP_FROM_QUARTER: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    seq_quarter_only ##0 ref_rise
    |=> seq_half_only)
    else $error("Step from quarter only went wrong");

  AST_STEP_FROM_HALF: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    seq_half_only ##0 ref_rise
    |=> seq_cleared)
    else $error("Step from half only went wrong");

  AST_QUARTER_AT_HALF: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE5
    $changed(divided_clock_out_o.quarter) |-> $rose(divided_clock_out_o.half))
    else $error("Quarter rate changed without a half rate rising edge");

  AST_OPEN_NO_EDGE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE6
    pins_s[scd_pkg::PIN_SEL] == scd_pkg::SEL_ECL
    && pins_s[scd_pkg::PIN_ECLP] == pins_s[scd_pkg::PIN_ECLN] |-> !ref_rise)
    else $error("Equal differential legs produced a reference edge");

  AST_STROBE_SINGLE: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    ref_rise |=> !ref_rise)
    else $error("Reference edge strobe lasted more than one cycle");

  AST_SETTLE_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE7
    !settle_q[1]
    |-> !ref_rise ##0 seq_cleared)
    else $error("Reference edge or output change before synchroniser settled");

  AST_EDGE_DETECT: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RULE1
    ref_rise
    == (ref_sel && !$past(ref_sel)))
    else $error("Reference edge strobe does not match selected level");

endmodule

`default_nettype wire

// ==== tb/scd_ref_model.sv ====
// Reference oscillator model driving the divider's source pins
`timescale 1ns/1ps
`default_nettype none
module scd_ref_model (
  input  wire logic       clock_i,
  input  wire logic       run_i,
  input  wire logic       open_i,
  input  wire logic [3:0] half_i,
  output var  logic       ecl_p_o,
  output var  logic       ecl_n_o,
  output var  logic       ttl_o
);
  logic [3:0] cnt_q = 4'h0;
  logic       lvl_q = 1'b0;
  logic       slow_q = 1'b0;
  always @(negedge clock_i) begin
    cnt_q <= (run_i && cnt_q < half_i) ? cnt_q + 4'h1 : 4'h0;
    if (run_i && cnt_q >= half_i) lvl_q <= ~lvl_q;
  end
  // Single-ended source at half rate, so a wrong select shows
  always @(posedge lvl_q) slow_q <= ~slow_q;
  // Open pair: both legs float and wander together
  assign ecl_p_o = lvl_q;
  assign ecl_n_o = open_i ? lvl_q : ~lvl_q;
  assign ttl_o   = slow_q;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the selectable clock divider
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic run = 1'b0;
  logic open = 1'b0;
  logic sel = 1'b0;
  logic [3:0] half = 4'h1;
  logic [7:0] rnd = 8'h34;
  logic ep, en, tt, prev_q;
  logic [1:0] n_q;
  int miscompares = 0;
  int check_count = 0;
  scd_pkg::scd_ref_pins_t pins, p1_q, p2_q;
  scd_pkg::scd_clk_out_t dout;
  wire logic ref_s = p2_q.sel ? p2_q.ttl : (p2_q.ecl_p & ~p2_q.ecl_n);
  always #50 clk = ~clk;
  assign pins = '{ecl_p: ep, ecl_n: en, ttl: tt, sel: sel};
  scd_ref_model scd_ref_model_inst (.clock_i(clk), .run_i(run), .open_i(open),
    .half_i(half), .ecl_p_o(ep), .ecl_n_o(en), .ttl_o(tt));
  scd_divider scd_divider_inst (.clock_i(clk), .rst_n_i(rst_n), .ref_pins_i(pins),
    .divided_clock_out_o(dout));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic scd_pkg::scd_clk_out_t exp_out(input logic [1:0] n);
    return '{half: n[0], half_n: ~n[0], quarter: n[1] ^ n[0], quarter_n: ~(n[1] ^ n[0])};
  endfunction
  task automatic check(input scd_pkg::scd_clk_out_t seen, input scd_pkg::scd_clk_out_t want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Expected divide state, fed through the same two-flop sampling delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= '0;
      p2_q <= '0;
      prev_q <= 1'b0;
      n_q <= 2'h0;
    end else begin
      p1_q <= pins;
      p2_q <= p1_q;
      prev_q <= ref_s;
      if (ref_s && !prev_q) n_q <= n_q + 2'h1;
    end
  end
  always @(negedge clk) check(dout, exp_out(n_q));
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    // Reset edge after time zero so every flop sees it
    #10 rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b1;
    // Corners first: differential, single-ended, open pair; then random
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      half = {1'b0, rnd[2:0]} | 4'h1;
      sel = (i == 1) || (i > 2 && rnd[7]);
      open = (i == 2) || (i > 2 && rnd[6:5] == 2'h0);
      repeat (40) @(negedge clk);
      if (i % 10 == 9) begin
        #30 rst_n = 1'b0;
        #10 check(dout, scd_pkg::OUT_RST);
        @(negedge clk);
        rst_n = 1'b1;
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
